// *** hdl/tms_top.sv ***
// Trigger model sequencer with range store and service request over AHB-Lite.
// Function
// - Each measurement function keeps its own range and autorange setting.
// - A range argument is the largest value to measure; range chosen internally.
// - The range argument is rounded to the nearest integer first.
// - A range query returns full scale of the present range.
// - One arm level, the second, precedes the trigger layer; triggering can be disabled.
// - Trigger settings never arm; only initiate arms.
// - External trigger source: one reading per external pulse.
// - Infinite trigger count keeps the model in the trigger layer.
// - Abort returns to idle and stays there until initiate.
// - External arm source waits for a pulse then enters trigger layer.
// - Immediate source: read at once and back to back.
// - Timer trigger source: first reading at once, then one per interval.
// - Reset sets immediate source, default trigger settings, idle model.
// - Service request asserts when an enabled status bit changes.
// - A serial poll releases the service request line.
// - One request per event register until it is cleared.
// - Reading an event register clears it; clear-status clears all.
// - Buffer full sets bit 9 of the measurement event register.
`timescale 1ns/1ns
`default_nettype none
module tms_top #(
  parameter int unsigned TIMER_DEFAULT = tms_pkg::TIMER_CYC
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic EXT_TRIG_IN,
  input wire logic READING_DONE_IN,
  input wire logic [15:0] MEAS_STATUS_IN,
  input wire logic SERIAL_POLL_IN,
  output logic START_READING_OUT,
  output logic ARMED_OUT,
  output logic SRQ_OUT
);
  import tms_pkg::*;
  logic ph_valid;
  logic ph_write;
  logic [31:0] ph_addr;
  logic do_init;
  logic do_abort;
  logic do_reset;
  logic do_cls;
  logic wr_cfg;
  tms_src_t trig_src;
  tms_src_t arm_src;
  logic trig_inf;
  logic [15:0] trig_count;
  logic [15:0] arm_count;
  logic [31:0] timer_reload;
  logic [2:0] range_sel [NUM_FUNC];
  logic autorange [NUM_FUNC];
  logic [1:0] query_func;
  logic [2:0] new_range;
  logic [15:0] meas_evt;
  logic [15:0] meas_ena;
  logic [15:0] status_prev;
  logic evt_read;
  logic srq;
  tms_state_t state;
  logic [15:0] trig_done;
  logic [15:0] arm_done;
  logic [31:0] timer_cnt;
  logic ext_prev;
  logic ext_pulse;
  logic timer_tick;
  logic [31:0] full_scale;

  assign HRESP_OUT = 1'b0;
  assign HREADYOUT_OUT = 1'b1;
  assign ext_pulse = EXT_TRIG_IN & ~ext_prev;
  assign do_init = ph_valid && ph_write && ph_addr == ADDR_CMD && HWDATA_IN[CMD_INIT_BIT];
  assign do_abort = ph_valid && ph_write && ph_addr == ADDR_CMD && HWDATA_IN[CMD_ABORT_BIT];
  assign do_reset = ph_valid && ph_write && ph_addr == ADDR_CMD && HWDATA_IN[CMD_RESET_BIT];
  assign do_cls = ph_valid && ph_write && ph_addr == ADDR_CMD && HWDATA_IN[CMD_CLS_BIT];
  assign wr_cfg = ph_valid && ph_write;
  assign evt_read = ph_valid && !ph_write && ph_addr == ADDR_MEAS_EVT;
  assign timer_tick = (timer_cnt == 32'h0000_0000);

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 32'h0000_0000;
    end else if (HREADY_IN) begin
      ph_valid <= HSEL_IN && HTRANS_IN[1];
      ph_write <= HWRITE_IN;
      ph_addr <= HADDR_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= EXT_TRIG_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      trig_src <= SRC_IMM;
      arm_src <= SRC_IMM;
      trig_inf <= 1'b0;
      trig_count <= TRIG_CNT_RST;
      arm_count <= ARM_CNT_RST;
      timer_reload <= 32'(TIMER_DEFAULT);
    end else if (do_reset) begin
      trig_src <= SRC_IMM;
      arm_src <= SRC_IMM;
      trig_inf <= 1'b0;
      trig_count <= TRIG_CNT_RST;
      arm_count <= ARM_CNT_RST;
      timer_reload <= 32'(TIMER_DEFAULT);
    end else if (wr_cfg) begin
      if (ph_addr == ADDR_TRIG_CFG) begin
        trig_src <= tms_src_t'(HWDATA_IN[1:0]);
        arm_src <= tms_src_t'(HWDATA_IN[3:2]);
        trig_inf <= HWDATA_IN[4];
      end else if (ph_addr == ADDR_TRIG_CNT) begin
        trig_count <= HWDATA_IN[15:0];
      end else if (ph_addr == ADDR_ARM_CNT) begin
        arm_count <= HWDATA_IN[15:0];
      end else if (ph_addr == ADDR_TIMER) begin
        timer_reload <= HWDATA_IN;
      end
    end
  end

  tms_range_sel #(.NUM_RANGE(NUM_RANGE)) u_range (
    .max_value_in({4'h0, HWDATA_IN[27:0]}),
    .range_out(new_range)
  );

  for (genvar f = 0; f < NUM_FUNC; f++) begin : g_func
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
        range_sel[f] <= 3'h0;
        autorange[f] <= 1'b0;
      end else if (wr_cfg && ph_addr == ADDR_RANGE_SET && HWDATA_IN[31:30] == 2'(f)) begin
        range_sel[f] <= new_range;
        autorange[f] <= HWDATA_IN[29];
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      query_func <= 2'h0;
    end else if (wr_cfg && ph_addr == ADDR_RANGE_QRY) begin
      query_func <= HWDATA_IN[1:0];
    end
  end

  always_comb begin
    full_scale = 32'h0000_0002;
    for (int i = 0; i < NUM_RANGE; i++) begin
      if (range_sel[query_func] == 3'(i)) begin
        full_scale = 32'(32'h0000_0002 * (32'h0000_000a ** i));
      end
    end
  end

  // idle, second arm layer, trigger layer, reading in progress.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state <= ST_IDLE;
      trig_done <= 16'h0000;
      arm_done <= 16'h0000;
      START_READING_OUT <= 1'b0;
      ARMED_OUT <= 1'b0;
    end else begin
      START_READING_OUT <= 1'b0;
      if (do_abort || do_reset) begin
        state <= ST_IDLE;
        ARMED_OUT <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (do_init) begin
              state <= ST_ARM2;
              arm_done <= 16'h0000;
              ARMED_OUT <= 1'b1;
            end
          end
          ST_ARM2: begin
            if (arm_src == SRC_IMM || (arm_src == SRC_EXT && ext_pulse) ||
                (arm_src == SRC_TIMER && timer_tick)) begin
              state <= ST_TRIG;
              trig_done <= 16'h0000;
              arm_done <= 16'(arm_done + 16'h0001);
              if (trig_src == SRC_IMM || trig_src == SRC_TIMER) begin
                START_READING_OUT <= 1'b1;
                state <= ST_MEAS;
              end
            end
          end
          ST_TRIG: begin
            if ((trig_src == SRC_EXT && ext_pulse) || trig_src == SRC_IMM ||
                (trig_src == SRC_TIMER && timer_tick)) begin
              START_READING_OUT <= 1'b1;
              state <= ST_MEAS;
            end
          end
          ST_MEAS: begin
            if (READING_DONE_IN) begin
              trig_done <= 16'(trig_done + 16'h0001);
              if (!trig_inf && 16'(trig_done + 16'h0001) >= trig_count) begin
                if (arm_done >= arm_count) begin
                  state <= ST_IDLE;
                  ARMED_OUT <= 1'b0;
                end else begin
                  state <= ST_ARM2;
                end
              end else begin
                state <= ST_TRIG;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // The interval restarts on every reading start so the first tick lands one interval later.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      timer_cnt <= 32'h0000_0000;
    end else if (START_READING_OUT || state == ST_IDLE) begin
      timer_cnt <= 32'(timer_reload - 32'h0000_0002);
    end else if (!timer_tick) begin
      timer_cnt <= 32'(timer_cnt - 32'h0000_0001);
    end
  end

  // buffer full bit nine.
  // A new transition in the clear cycle wins over the clear so no event is lost.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      status_prev <= 16'h0000;
      meas_evt <= 16'h0000;
      meas_ena <= 16'h0000;
    end else begin
      status_prev <= MEAS_STATUS_IN;
      if (evt_read || do_cls) begin
        meas_evt <= MEAS_STATUS_IN ^ status_prev;
      end else begin
        meas_evt <= meas_evt | (MEAS_STATUS_IN ^ status_prev);
      end
      if (wr_cfg && ph_addr == ADDR_MEAS_ENA) begin
        meas_ena <= HWDATA_IN[15:0];
      end
    end
  end

  tms_srq u_srq (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .event_in(meas_evt),
    .enable_in(meas_ena),
    .clear_in(evt_read || do_cls),
    .poll_in(SERIAL_POLL_IN),
    .srq_out(srq)
  );

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      SRQ_OUT <= 1'b0;
    end else begin
      SRQ_OUT <= srq;
    end
  end

  always_comb begin
    HRDATA_OUT = 32'h0000_0000;
    if (!ph_valid || ph_write) begin
      HRDATA_OUT = 32'h0000_0000;
    end else if (ph_addr == ADDR_TRIG_CFG) begin
      HRDATA_OUT = {27'h0, trig_inf, arm_src, trig_src};
    end else if (ph_addr == ADDR_TRIG_CNT) begin
      HRDATA_OUT = {16'h0, trig_count};
    end else if (ph_addr == ADDR_ARM_CNT) begin
      HRDATA_OUT = {16'h0, arm_count};
    end else if (ph_addr == ADDR_TIMER) begin
      HRDATA_OUT = timer_reload;
    end else if (ph_addr == ADDR_RANGE_QRY) begin
      HRDATA_OUT = full_scale;
    end else if (ph_addr == ADDR_MEAS_EVT) begin
      HRDATA_OUT = {16'h0, meas_evt};
    end else if (ph_addr == ADDR_MEAS_ENA) begin
      HRDATA_OUT = {16'h0, meas_ena};
    end else if (ph_addr == ADDR_STATE) begin
      HRDATA_OUT = {29'h0, autorange[query_func], ARMED_OUT, state == ST_TRIG || state == ST_MEAS};
    end else if (ph_addr == ADDR_POLL) begin
      HRDATA_OUT = {25'h0, srq, 6'h0};
    end
  end

  abort_idle_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    do_abort |=> state == ST_IDLE && !ARMED_OUT) else $error("abort did not idle");
  idle_stays_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    state == ST_IDLE && !do_init |=> state == ST_IDLE) else $error("left idle without initiate");
  ext_one_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    state == ST_TRIG && trig_src == SRC_EXT && !ext_pulse |=> !START_READING_OUT)
    else $error("reading without pulse");
  inf_stay_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    state == ST_MEAS && trig_inf && !do_abort && !do_reset |=> state != ST_IDLE && state != ST_ARM2)
    else $error("left trigger layer with infinite count");
  reset_src_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    do_reset |=> trig_src == SRC_IMM && state == ST_IDLE) else $error("reset defaults wrong");
  arm_ext_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    state == ST_ARM2 && arm_src == SRC_EXT && !ext_pulse && !do_abort && !do_reset |=> state == ST_ARM2)
    else $error("arm layer left without pulse");
  imm_start_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    $past(state) == ST_ARM2 && state == ST_MEAS |-> START_READING_OUT) else $error("no reading on entry");
  evt_change_a: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    MEAS_STATUS_IN[BUF_FULL_BIT] != status_prev[BUF_FULL_BIT] |=> meas_evt[BUF_FULL_BIT])
    else $error("buffer full change not latched");
endmodule : tms_top
`default_nettype wire

// *** include/tms_pkg.sv ***
// Package with constants, register map and types for the trigger model and service request block.
package tms_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Timer interval default in microseconds.
  localparam int unsigned TIMER_US = 50000;
  localparam int unsigned TIMER_CYC = (TIMER_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned NUM_FUNC = 4;
  localparam int unsigned NUM_RANGE = 8;
  localparam logic [31:0] ADDR_CMD = 32'h0000_0000;
  localparam logic [31:0] ADDR_TRIG_CFG = 32'h0000_0004;
  localparam logic [31:0] ADDR_TRIG_CNT = 32'h0000_0008;
  localparam logic [31:0] ADDR_ARM_CNT = 32'h0000_000c;
  localparam logic [31:0] ADDR_TIMER = 32'h0000_0010;
  localparam logic [31:0] ADDR_RANGE_SET = 32'h0000_0014;
  localparam logic [31:0] ADDR_RANGE_QRY = 32'h0000_0018;
  localparam logic [31:0] ADDR_MEAS_EVT = 32'h0000_001c;
  localparam logic [31:0] ADDR_MEAS_ENA = 32'h0000_0020;
  localparam logic [31:0] ADDR_STATE = 32'h0000_0024;
  localparam logic [31:0] ADDR_POLL = 32'h0000_0028;
  localparam int unsigned CMD_INIT_BIT = 0;
  localparam int unsigned CMD_ABORT_BIT = 1;
  localparam int unsigned CMD_RESET_BIT = 2;
  localparam int unsigned CMD_CLS_BIT = 3;
  localparam int unsigned BUF_FULL_BIT = 9;
  localparam int unsigned SRQ_POLL_BIT = 6;
  localparam logic [15:0] TRIG_CNT_RST = 16'h0001;
  localparam logic [15:0] ARM_CNT_RST = 16'h0001;
  typedef enum logic [1:0] {SRC_IMM, SRC_TIMER, SRC_EXT, SRC_NONE} tms_src_t;
  typedef enum {ST_IDLE, ST_ARM2, ST_TRIG, ST_MEAS} tms_state_t;
endpackage : tms_pkg

// *** hdl/tms_range_sel.sv ***
// Range selection from a maximum-to-measure argument for one function.
`timescale 1ns/1ns
`default_nettype none
module tms_range_sel #(
  parameter int unsigned NUM_RANGE = tms_pkg::NUM_RANGE
) (
  input wire logic [31:0] max_value_in,
  output logic [2:0] range_out
);
  import tms_pkg::*;
  logic [31:0] rounded;
  // round to integer.
  // The argument carries four fraction bits; adding a half rounds it.
  assign rounded = 32'((max_value_in + 32'h0000_0008) >> 4);
  // choose matching range.
  // Decades from 2 upward; the smallest range holding the value wins.
  always_comb begin
    range_out = 3'(NUM_RANGE - 1);
    for (int i = NUM_RANGE - 1; i >= 0; i--) begin
      if (rounded <= (32'h0000_0002 * (32'h0000_000a ** i))) begin
        range_out = 3'(i);
      end
    end
  end
endmodule : tms_range_sel
`default_nettype wire

// *** hdl/tms_srq.sv ***
// Service request generation from the measurement event register.
`timescale 1ns/1ns
`default_nettype none
module tms_srq (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [15:0] event_in,
  input wire logic [15:0] enable_in,
  input wire logic clear_in,
  input wire logic poll_in,
  output logic srq_out
);
  import tms_pkg::*;
  logic raised;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      raised <= 1'b0;
      srq_out <= 1'b0;
    end else if (clear_in) begin
      raised <= 1'b0;
      srq_out <= 1'b0;
    end else if (!raised && |(event_in & enable_in)) begin
      raised <= 1'b1;
      srq_out <= 1'b1;
    end else if (poll_in) begin
      srq_out <= 1'b0;
    end
  end
  srq_once_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(srq_out) |-> !$past(raised)) else $error("second request before clear");
  srq_poll_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    poll_in && raised && !clear_in |=> !srq_out) else $error("poll did not release request");
endmodule : tms_srq
`default_nettype wire

// *** dv/tms_ctrl_model.sv ***
// Model of the bus controller and the reading engine facing the trigger block.
`timescale 1ns/1ns
`default_nettype none
module tms_ctrl_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic srq_in,
  input wire logic poll_en_in,
  output logic done_out,
  output logic poll_out
);
  logic [1:0] busy;
  logic polled;
  // A reading ends three cycles after it starts, so back-to-back starts show a real gap.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy <= 2'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= (busy == 2'h1);
      if (start_in) begin
        busy <= 2'h2;
      end else if (busy != 2'h0) begin
        busy <= busy - 2'h1;
      end
    end
  end
  // poll on request
  // The line is watched and one poll is sent per request, never a stream of polls.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      poll_out <= 1'b0;
      polled <= 1'b0;
    end else begin
      poll_out <= srq_in && poll_en_in && !polled && !poll_out;
      polled <= srq_in && (polled || poll_out);
    end
  end
endmodule : tms_ctrl_model
`default_nettype wire

// *** dv/test_trigger_model_and_service_request.sv ***
// Self-checking bench for the trigger model and service request block.
`timescale 1ns/1ns
`default_nettype none
module test_trigger_model_and_service_request;
  import tms_pkg::*;
  localparam int unsigned TMR = 20;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic ext = 1'b0;
  logic [15:0] stat = 16'h0;
  logic poll_en = 1'b0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic done;
  logic poll;
  logic start;
  logic armed;
  logic srq;
  int mismatches = 0;
  int checked = 0;
  int starts = 0;
  int polls = 0;
  int n0;
  logic [31:0] fs [4] = '{32'h2, 32'h14, 32'h7d0, 32'hc8};
  logic [31:0] rs [4] = '{32'h0000_0026, 32'h6000_0147, 32'h8000_3e80, 32'hc000_0960};
  always #25 clk = ~clk;
  tms_top #(.TIMER_DEFAULT(TMR)) u_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .EXT_TRIG_IN(ext),
    .READING_DONE_IN(done), .MEAS_STATUS_IN(stat), .SERIAL_POLL_IN(poll), .START_READING_OUT(start),
    .ARMED_OUT(armed), .SRQ_OUT(srq));
  tms_ctrl_model u_ctrl (.clk_in(clk), .rst_b_in(rst_b), .start_in(start), .srq_in(srq),
    .poll_en_in(poll_en), .done_out(done), .poll_out(poll));
  always @(posedge clk) begin
    if (start === 1'b1) starts <= starts + 1;
    if (poll === 1'b1) polls <= polls + 1;
  end
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk
  // Address phase is held until hready is seen, then the data phase likewise.
  // Only the watchdog ends a wait, so a stuck slave shows up as a timeout.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, exp, what);
  endtask : rd
  task automatic pulse;
    @(posedge clk);
    ext <= 1'b1;
    tk(2);
    ext <= 1'b0;
    tk(2);
  endtask : pulse
  initial begin
    #(50 * 5000);
    mismatches++;
    stop_test();
  end
  initial begin
    tk(2);
    rst_b <= 1'b1;
    rd(ADDR_TRIG_CNT, {16'h0, TRIG_CNT_RST}, "trigger count default");
    rd(ADDR_ARM_CNT, {16'h0, ARM_CNT_RST}, "arm count default");
    rd(ADDR_STATE, 32'h0, "idle after reset");
    rd(32'h0000_0040, 32'h0, "unmapped read");
    chk(32'(hresp), 32'h0, "bus response");
    // Settings alone must not arm; external trigger with infinite count.
    wr(ADDR_TRIG_CFG, 32'h12);
    tk(4);
    chk(32'(armed), 32'h0, "armed by settings");
    wr(ADDR_CMD, 32'h1);
    tk(5);
    chk(32'(starts), 32'h0, "reading before pulse");
    repeat (3) pulse();
    tk(4);
    chk(32'(starts), 32'h3, "one reading per pulse");
    chk(32'(armed), 32'h1, "left trigger layer");
    wr(ADDR_CMD, 32'h2);
    tk(2);
    chk(32'(armed), 32'h0, "armed after abort");
    pulse();
    tk(4);
    chk(32'(starts), 32'h3, "reading after abort");
    // External second arm layer, immediate trigger, count of three.
    wr(ADDR_TRIG_CNT, 32'h3);
    wr(ADDR_TRIG_CFG, 32'h8);
    n0 = starts;
    wr(ADDR_CMD, 32'h1);
    tk(5);
    chk(32'(starts), 32'(n0), "reading before arm pulse");
    pulse();
    tk(16);
    chk(32'(starts), 32'(n0 + 3), "back to back readings");
    chk(32'(armed), 32'h0, "idle after count");
    // Timer source: first reading at once, the rest one interval apart.
    wr(ADDR_TRIG_CFG, 32'h1);
    n0 = starts;
    wr(ADDR_CMD, 32'h1);
    tk(8);
    chk(32'(starts), 32'(n0 + 1), "first timer reading");
    tk(3 * TMR);
    chk(32'(starts), 32'(n0 + 3), "timer readings");
    // Reset command restores the defaults.
    wr(ADDR_TRIG_CFG, 32'h1e);
    wr(ADDR_CMD, 32'h1);
    n0 = starts;
    pulse();
    chk(32'(starts), 32'(n0), "reading with arming disabled");
    chk(32'(armed), 32'h1, "armed while disabled");
    wr(ADDR_CMD, 32'h4);
    tk(2);
    chk(32'(armed), 32'h0, "armed after reset");
    rd(ADDR_TRIG_CFG, 32'h0, "sources after reset");
    rd(ADDR_TRIG_CNT, {16'h0, TRIG_CNT_RST}, "count after reset");
    // Ranges per function; 2.375 rounds to 2 and 20.4375 to 20.
    for (int f = 0; f < 4; f++) wr(ADDR_RANGE_SET, rs[f]);
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_RANGE_QRY, 32'(f));
      rd(ADDR_RANGE_QRY, fs[f], "full scale");
      rd(ADDR_STATE, {29'h0, f == 1, 2'h0}, "autorange");
    end
    // Service request on the buffer-full bit.
    wr(ADDR_MEAS_ENA, 32'h200);
    wr(ADDR_CMD, 32'h8);
    stat <= 16'h0200;
    tk(4);
    chk(32'(srq), 32'h1, "request on rise");
    poll_en <= 1'b1;
    tk(6);
    chk(32'(srq), 32'h0, "request after poll");
    stat <= 16'h0000;
    tk(6);
    chk(32'(polls), 32'h1, "second request");
    rd(ADDR_MEAS_EVT, 32'h200, "event bits");
    rd(ADDR_MEAS_EVT, 32'h0, "event after read");
    stat <= 16'h0200;
    tk(8);
    chk(32'(polls), 32'h2, "request after read");
    stat <= 16'h0000;
    tk(8);
    chk(32'(polls), 32'h2, "request while set");
    wr(ADDR_CMD, 32'h8);
    stat <= 16'h0200;
    tk(8);
    chk(32'(polls), 32'h3, "request after clear");
    rd(ADDR_MEAS_EVT, 32'h200, "event after clear");
    stat <= 16'h0000;
    tk(8);
    chk(32'(polls), 32'h4, "request on fall");
    stop_test();
  end
endmodule : test_trigger_model_and_service_request
`default_nettype wire
